// ===== pkg/pca_consts.vh
/*
  constants for the counter array block: register offsets, field positions,
  reset values and clock source codes. assumes byte addressing on a
  32-bit avalon-mm slave.
*/
`ifndef COUNTER_ARRAY_CONSTS_VH
`define COUNTER_ARRAY_CONSTS_VH
`define OFS_CTRL       8'h00
`define OFS_MODE       8'h04
`define OFS_COUNT      8'h08
`define OFS_STATUS     8'h0C
`define OFS_WD_KICK    8'h10
`define OFS_CAP0       8'h20
`define CTRL_RUN       0
`define CTRL_SRC_LO    1
`define CTRL_SRC_HI    3
`define CTRL_RESET     16'h0001
`define MODE_RESET     16'h0000
`define MODE_CAPTURE   3'h0
`define MODE_SWTIMER   3'h1
`define MODE_HSOUT     3'h2
`define MODE_PWM8      3'h3
`define MODE_PWM16     3'h4
`define MODE_FREQ      3'h5
`define SRC_DIV12      3'h0
`define SRC_DIV4       3'h1
`define SRC_T0OVF      3'h2
`define SRC_EXTCNT     3'h3
`define SRC_SYSCLK     3'h4
`define SRC_XOSC8      3'h5
`define DIV12_LAST     4'hB
`define DIV4_LAST      4'h3
`define XOSC_LAST      3'h7
`define WD_LIMIT       16'hFFFF
`endif

// ===== hdl/counter_array_capture_compare.v
/*
  counter array: one 16-bit time base shared by five capture/compare
  modules, registers over avalon-mm with waitrequest.
  assumes pins arrive asynchronous to REF_CLK; crossbar routing lives outside.
*/
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pca_consts.vh"
// Function
// - one shared 16-bit time base, five modules
// - six selectable time base clock sources
// - each module runs in one mode
// - module four also offers watchdog
// - watchdog enabled on module four after reset
// - module io and count input reach pins
// - external oscillator source is synchronised to REF_CLK and divided by eight
module counter_array_capture_compare (
  input  wire        REF_CLK,
  input  wire        RSTN,
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  input  wire        EXTERNAL_COUNT_INPUT,
  input  wire        TIMER0_OVERFLOW,
  input  wire        EXT_OSC,
  input  wire [4:0]  CAPTURE_IN,
  output wire [4:0]  MODULE_OUT,
  output reg         MODULE_WATCHDOG_RESET
);
  reg  [15:0] ctrl;
  reg  [15:0] count;
  reg         overflow;
  reg  [4:0]  cap_flag;
  reg  [14:0] mode;          // three bits per module
  reg         wd_enable;
  reg  [15:0] wd_count;
  reg  [3:0]  prescale;
  reg  [2:0]  xosc_div;
  reg  [1:0]  ext_cnt_sync;
  reg  [1:0]  t0_sync;
  reg  [1:0]  xosc_sync;
  reg         ext_cnt_last;
  reg         t0_last;
  reg         xosc_last;
  reg  [4:0]  cap_s1;
  reg  [4:0]  cap_s2;
  reg  [4:0]  cap_last;
  reg         tick;
  reg  [15:0] next_count;
  reg         next_overflow;
  reg  [4:0]  next_cap_flag;
  reg         next_wd_enable;
  reg  [15:0] next_wd_count;
  reg  [31:0] next_readdata;
  reg         next_waitrequest;
  wire [79:0] cmp_flat;      // sixteen bits per module
  wire [79:0] cap_flat;
  wire [4:0]  out_bit;
  wire [4:0]  ev_cap;
  wire [2:0]  src       = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];
  wire        wr        = AVS_WRITE & AVS_WAITREQUEST;
  wire        rd        = AVS_READ & AVS_WAITREQUEST;
  wire        wr_ctrl   = wr & (AVS_ADDRESS == `OFS_CTRL);
  wire        wr_mode   = wr & (AVS_ADDRESS == `OFS_MODE);
  wire        wr_count  = wr & (AVS_ADDRESS == `OFS_COUNT);
  wire        wr_status = wr & (AVS_ADDRESS == `OFS_STATUS);
  wire        wr_kick   = wr & (AVS_ADDRESS == `OFS_WD_KICK);
  wire        hit_cmp   = (AVS_ADDRESS[7:5] == 3'h1) & (AVS_ADDRESS[1:0] == 2'h0);
  wire [2:0]  sel       = AVS_ADDRESS[4:2];
  wire        wrap      = tick & (count == 16'hFFFF);
  wire        edge_ext  = ~ext_cnt_sync[1] & ext_cnt_last;
  wire        edge_t0   = t0_sync[1] & ~t0_last;
  wire        edge_xosc = xosc_sync[1] & ~xosc_last;
  // pins pass two flops before use; only the second stage is looked at
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_cnt_sync <= 2'h0;
      t0_sync      <= 2'h0;
      xosc_sync    <= 2'h0;
      cap_s1       <= 5'h00;
      cap_s2       <= 5'h00;
    end else begin
      ext_cnt_sync <= {ext_cnt_sync[0], EXTERNAL_COUNT_INPUT};
      t0_sync      <= {t0_sync[0], TIMER0_OVERFLOW};
      xosc_sync    <= {xosc_sync[0], EXT_OSC};
      cap_s1       <= CAPTURE_IN;
      cap_s2       <= cap_s1;
    end
  end
  // history of the synchronised levels; resets to the idle-low pin level
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_cnt_last <= 1'b0;
      t0_last      <= 1'b0;
      xosc_last    <= 1'b0;
      cap_last     <= 5'h00;
    end else begin
      ext_cnt_last <= ext_cnt_sync[1];
      t0_last      <= t0_sync[1];
      xosc_last    <= xosc_sync[1];
      cap_last     <= cap_s2;
    end
  end
  // source select; the oscillator path is free of the system prescaler
  always @* begin
    case (src)
      `SRC_DIV12:  tick = (prescale == `DIV12_LAST);
      `SRC_DIV4:   tick = (prescale[1:0] == `DIV4_LAST & prescale[3:2] == 2'h0);
      `SRC_T0OVF:  tick = edge_t0;
      `SRC_EXTCNT: tick = edge_ext;
      `SRC_SYSCLK: tick = 1'b1;
      `SRC_XOSC8:  tick = edge_xosc & (xosc_div == `XOSC_LAST);
      default:     tick = 1'b0;
    endcase
    if (!ctrl[`CTRL_RUN])
      tick = 1'b0;
  end
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prescale <= 4'h0;
    end else if ((src == `SRC_DIV12 && prescale == `DIV12_LAST) ||
                 (src != `SRC_DIV12 && prescale == `DIV4_LAST)) begin
      prescale <= 4'h0;
    end else begin
      prescale <= prescale + 4'h1;
    end
  end
  // the oscillator divider runs whatever source is selected
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      xosc_div <= 3'h0;
    end else if (edge_xosc) begin
      xosc_div <= xosc_div + 3'h1;
    end
  end
  // a software load of the count overrides a tick in the same cycle
  always @* begin
    next_count = count;
    if (tick)
      next_count = count + 16'h0001;
    if (wr_count)
      next_count = AVS_WRITEDATA[15:0];
  end
  // a flag set in the cycle of its software clear stays set
  always @* begin
    next_overflow = overflow;
    next_cap_flag = cap_flag;
    if (wr_status) begin
      next_overflow = overflow & ~AVS_WRITEDATA[0];
      next_cap_flag = cap_flag & ~AVS_WRITEDATA[7:3];
    end
    if (wrap)
      next_overflow = 1'b1;
    next_cap_flag = next_cap_flag | ev_cap;
  end
  // the watchdog can only be switched off; only a reset turns it back on
  always @* begin
    next_wd_enable = wd_enable;
    next_wd_count  = wd_count;
    if (wr_status)
      next_wd_enable = wd_enable & ~AVS_WRITEDATA[8];
    if (wr_kick)
      next_wd_count = 16'h0000;
    else if (wd_enable && tick && wd_count != `WD_LIMIT)
      next_wd_count = wd_count + 16'h0001;
  end
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= AVS_WRITEDATA[15:0];
    end
  end
  // mode writes are dropped while the watchdog guards module four
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode <= 15'h0000;
    end else if (wr_mode && !wd_enable) begin
      mode <= AVS_WRITEDATA[14:0];
    end
  end
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      count    <= 16'h0000;
      overflow <= 1'b0;
      cap_flag <= 5'h00;
    end else begin
      count    <= next_count;
      overflow <= next_overflow;
      cap_flag <= next_cap_flag;
    end
  end
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wd_enable <= 1'b1;
      wd_count  <= 16'h0000;
    end else begin
      wd_enable <= next_wd_enable;
      wd_count  <= next_wd_count;
    end
  end
  // per-module logic
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : module_slot
      reg  [15:0] cmp_r;
      reg  [15:0] cap_r;
      reg         out_r;
      wire [2:0]  m        = mode[3*i+2:3*i];
      wire        cap_edge = cap_s2[i] ^ cap_last[i];
      wire        hit      = tick & (count == cmp_r);
      assign ev_cap[i] = (m == `MODE_CAPTURE & cap_edge) | (m == `MODE_SWTIMER & hit);
      assign cmp_flat[16*i+15:16*i] = cmp_r;
      assign cap_flat[16*i+15:16*i] = cap_r;
      assign out_bit[i] = out_r;
      // compare value is writable in every mode
      always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          cmp_r <= 16'h0000;
        end else if (wr && hit_cmp && sel == i) begin
          cmp_r <= AVS_WRITEDATA[15:0];
        end
      end
      always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          cap_r <= 16'h0000;
        end else if (m == `MODE_CAPTURE && cap_edge) begin
          cap_r <= count;
        end
      end
      // capture and timer modes hold the module output low
      always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          out_r <= 1'b0;
        end else begin
          case (m)
            `MODE_HSOUT: begin
              if (hit)
                out_r <= ~out_r;
            end
            `MODE_PWM8: begin
              out_r <= (count[7:0] >= cmp_r[7:0]);
            end
            `MODE_PWM16: begin
              out_r <= (count >= cmp_r);
            end
            `MODE_FREQ: begin
              if (tick && count[7:0] == cmp_r[7:0])
                out_r <= ~out_r;
            end
            default: begin
              out_r <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate
  assign MODULE_OUT = out_bit;
  // unmapped reads give zero; compare slots past the fifth as well
  always @* begin
    next_readdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      `OFS_CTRL:    next_readdata = {16'h0000, ctrl};
      `OFS_MODE:    next_readdata = {17'h0_0000, mode};
      `OFS_COUNT:   next_readdata = {16'h0000, count};
      `OFS_STATUS:  next_readdata = {23'h00_0000, wd_enable, cap_flag, 2'h0, overflow};
      `OFS_WD_KICK: next_readdata = {16'h0000, wd_count};
      default: begin
        if (hit_cmp && sel < 3'h5)
          next_readdata = {cap_flat[16*sel +: 16], cmp_flat[16*sel +: 16]};
      end
    endcase
  end
  // one wait cycle, then a one-cycle answer; waitrequest idles high
  always @* begin
    next_waitrequest = ~(rd | wr);
  end
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= next_waitrequest;
      if (rd)
        AVS_READDATA <= next_readdata;
    end
  end
  // expiry is held until a kick, a disable or a reset
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODULE_WATCHDOG_RESET <= 1'b0;
    end else begin
      MODULE_WATCHDOG_RESET <= wd_enable & (wd_count == `WD_LIMIT);
    end
  end
endmodule

// ===== tb/pca_properties.sv
/*
  port checker for the counter array block.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`include "pca_consts.vh"
module counter_array_properties (
  input wire        REF_CLK,
  input wire        RSTN,
  input wire [7:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire [4:0]  MODULE_OUT,
  input wire        MODULE_WATCHDOG_RESET
);
  logic [16:0] cyc;
  // cycles since reset, saturating: a tick is never faster than the clock
  always @(posedge REF_CLK or negedge RSTN)
    if (!RSTN) cyc <= 17'h0_0000;
    else if (!cyc[16]) cyc <= cyc + 17'h0_0001;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  chk_wait_cause: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");
  chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("request not answered");
  chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  chk_data_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without read");
  chk_count_width: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == `OFS_COUNT |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("count wider than 16 bits");
  chk_wd_reset_idle: assert property ($rose(RSTN) |->
    !MODULE_WATCHDOG_RESET && MODULE_OUT == 5'h00) else $error("outputs after reset");
  chk_wd_min_time: assert property (MODULE_WATCHDOG_RESET |-> cyc >= 17'h0_FFF0)
    else $error("watchdog expired early");
  chk_wd_level: assert property (MODULE_WATCHDOG_RESET && !AVS_WRITE
    |=> MODULE_WATCHDOG_RESET) else $error("watchdog level dropped");
  chk_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == 8'h40 |-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read");
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property ($rose(MODULE_WATCHDOG_RESET));
endmodule
bind counter_array_capture_compare counter_array_properties chk_i (.REF_CLK(REF_CLK),
  .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .MODULE_OUT(MODULE_OUT),
  .MODULE_WATCHDOG_RESET(MODULE_WATCHDOG_RESET));

// ===== tb/pin_model.sv
/*
  far-side pins: count input, timer zero overflow, slow oscillator, capture pins.
  assumes the block synchronises every pin itself.
*/
`timescale 1ns/100ps
module pin_model #(parameter int PER = 8) (
  input  wire        clk,
  output logic       ext_cnt,
  output logic       t0_ovf,
  output logic       osc,
  output logic [4:0] cap
);
  int n = 0;
  initial {ext_cnt, t0_ovf, osc, cap} = 8'h00;
  always @(posedge clk) begin
    n <= n + 1;
    osc <= ~osc;
    if (n % PER == 0) ext_cnt <= ~ext_cnt;
    t0_ovf <= (n % 12 == 0);
    if (n % 20 == 0) cap <= cap + 5'h01;
  end
endmodule

// ===== tb/counter_array_capture_compare_test.sv
/*
  register-level bench for the counter array block.
  assumes an avalon-mm slave answering one cycle after it takes a request.
*/
`timescale 1ns/100ps
`include "pca_consts.vh"
module counter_array_capture_compare_test;
  logic        REF_CLK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, q, a;
  logic        AVS_WAITREQUEST, ext_cnt, t0, osc, MODULE_WATCHDOG_RESET;
  logic [4:0]  cap, MODULE_OUT;
  int          n_mismatch = 0, num_checks = 0;
  int          lo[6] = '{18, 58, 18, 13, 238, 13};
  int          hi[6] = '{22, 64, 23, 17, 248, 17};
  counter_array_capture_compare dut (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXTERNAL_COUNT_INPUT(ext_cnt),
    .TIMER0_OVERFLOW(t0), .EXT_OSC(osc), .CAPTURE_IN(cap), .MODULE_OUT(MODULE_OUT),
    .MODULE_WATCHDOG_RESET(MODULE_WATCHDOG_RESET));
  pin_model pins (.clk(REF_CLK), .ext_cnt(ext_cnt), .t0_ovf(t0), .osc(osc), .cap(cap));
  initial forever #2.5 REF_CLK = ~REF_CLK;
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    // the request stands until a rising edge samples waitrequest low
    @(posedge REF_CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge REF_CLK);
    r = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset;
    RSTN <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    RSTN <= 1'b1;
    @(posedge REF_CLK);
  endtask
  initial begin
    repeat (90000) @(posedge REF_CLK);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    do_reset;
    acc(0, `OFS_CTRL, 0, q); chk(q, 32'h0000_0001);
    acc(0, `OFS_STATUS, 0, q); chk(q[8], 1'b1);
    acc(1, `OFS_MODE, 32'h0000_58D1, q);
    acc(0, `OFS_MODE, 0, q); chk(q, 32'h0000_0000);
    // watchdog on the undivided clock: 65535 ticks to expiry
    acc(1, `OFS_CTRL, 32'h0000_0009, q);
    acc(1, `OFS_WD_KICK, 0, q);
    repeat (60000) @(posedge REF_CLK);
    chk(MODULE_WATCHDOG_RESET, 1'b0);
    repeat (6000) @(posedge REF_CLK);
    chk(MODULE_WATCHDOG_RESET, 1'b1);
    do_reset;
    chk(MODULE_WATCHDOG_RESET, 1'b0);
    acc(0, `OFS_STATUS, 0, q); chk(q[8], 1'b1);
    acc(1, `OFS_STATUS, 32'h0000_0100, q);
    acc(0, `OFS_STATUS, 0, q); chk(q[8], 1'b0);
    acc(1, `OFS_MODE, 32'h0000_58D1, q);
    acc(0, `OFS_MODE, 0, q); chk(q[14:0], 15'h58D1);
    chk({MODULE_OUT[3:2], MODULE_OUT[0]}, 3'h6);
    acc(1, 8'h40, 32'hFFFF_FFFF, q);
    acc(0, 8'h40, 0, q); chk(q, 32'h0000_0000);
    for (int s = 0; s < 6; s++) begin
      acc(1, `OFS_CTRL, {28'h000_0000, s[2:0], 1'b1}, q);
      acc(0, `OFS_COUNT, 0, a);
      repeat (240) @(posedge REF_CLK);
      acc(0, `OFS_COUNT, 0, q);
      q = {16'h0000, q[15:0] - a[15:0]};
      chk(q >= lo[s] && q <= hi[s], 1'b1);
    end
    acc(1, `OFS_CTRL, 32'h0000_0009, q);
    acc(1, `OFS_COUNT, 32'h0000_FFF0, q);
    repeat (40) @(posedge REF_CLK);
    acc(0, `OFS_STATUS, 0, q); chk(q[0], 1'b1);
    acc(1, `OFS_STATUS, 32'h0000_0001, q);
    acc(0, `OFS_STATUS, 0, q); chk(q[0], 1'b0);
    chk(q[3], 1'b1);
    end_of_test;
  end
endmodule
